//--- logic/fspc_regs.svh
/*
  register offsets, field positions, reset values and masks of the flash
  self-programming control block.
  assumes byte-wide register access at 20-bit cpu addresses.
*/
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH
// Overview of operation
// - mode control register resets to 0x08: code area, inhibited, read mode.
// - area select bit 0 targets code flash, 1 targets data flash.
// - inhibit bit 0 allows write and erase, 1 blocks both.
// - mode bit 0 is normal read, 1 is self-programming.
// - frequency and command registers reset to 0x00, sequencer stopped.
// - 5-bit frequency code is MHz minus one, 1 to 16 MHz.
// - start bit written 1 runs the command, written 0 stops it.
// - command 000 means none; only 000, 001, 100 are legal.
// - command 001 writes the 4-byte buffer word at the pointer address.
// - command 100 erases blocks from pointer block through end block.
// - end flag sets at finish, clears only after start bit cleared.
// - sequencer and erase error flags hold until next activation.
// - start holds the cpu in wait until the operation ends.
// - four buffer byte registers form the 32-bit write word.

`define FSPC_ADDR_FREQ    20'hf00be
`define FSPC_ADDR_MODE    20'hf00c0
`define FSPC_ADDR_CMD     20'hf00c1
`define FSPC_ADDR_PTR_L   20'hf00c2
`define FSPC_ADDR_PTR_H   20'hf00c3
`define FSPC_ADDR_END_L   20'hf00c4
`define FSPC_ADDR_END_H   20'hf00c5
`define FSPC_ADDR_STAT_L  20'hf00c6
`define FSPC_ADDR_STAT_H  20'hf00c7
`define FSPC_ADDR_WB0     20'hf00c8

`define FSPC_MODE_RESET   8'h08
`define FSPC_FREQ_RESET   8'h00
`define FSPC_CMD_RESET    8'h00
`define FSPC_MODE_WMASK   8'h2a
`define FSPC_FREQ_WMASK   8'h1f
`define FSPC_CMD_WMASK    8'h87

`define FSPC_AREA_BIT     5
`define FSPC_INHIBIT_BIT  3
`define FSPC_SPM_BIT      1
`define FSPC_START_BIT    7
`define FSPC_END_BIT      6
`define FSPC_SEQERR_BIT   4
`define FSPC_WRERR_BIT    1
`define FSPC_ERERR_BIT    0

`define FSPC_FREQ_MAX     5'h0f
`define FSPC_BLK_CODE     16'h0400
`define FSPC_BLK_DATA     16'h0200
`define FSPC_SHIFT_CODE   10
`define FSPC_SHIFT_DATA   9
`endif

//--- logic/fspc_pkg.sv
/*
  types shared by the flash self-programming control modules.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package fspc_pkg;
  typedef enum logic [2:0] {
    FSPC_CMD_NONE  = 3'b000,
    FSPC_CMD_WRITE = 3'b001,
    FSPC_CMD_ERASE = 3'b100
  } fspc_cmd_type;

  typedef enum logic [1:0] {
    FSPC_ST_IDLE  = 2'b00,
    FSPC_ST_ISSUE = 2'b01,
    FSPC_ST_WAIT  = 2'b10,
    FSPC_ST_DONE  = 2'b11
  } fspc_state_type;
endpackage
`default_nettype wire

//--- logic/fspc_seq_if.sv
/*
  carrier between the register file and the sequencer engine.
  assumes both ends share clk and rst_n.
*/
`timescale 1ns/100ps
`default_nettype none
interface fspc_seq_if;
  logic        start;
  logic [2:0]  cmd;
  logic        area;
  logic        inhibit;
  logic        spm;
  logic [4:0]  freq;
  logic [15:0] ptr;
  logic [15:0] end_addr;
  logic [31:0] wdata;
  logic        act;
  logic        done;
  logic        seq_err;
  logic        wr_err;
  logic        er_err;
  logic        busy;

  modport ctrl (output start, cmd, area, inhibit, spm, freq, ptr, end_addr, wdata,
                input act, done, seq_err, wr_err, er_err, busy);
  modport engine (input start, cmd, area, inhibit, spm, freq, ptr, end_addr, wdata,
                  output act, done, seq_err, wr_err, er_err, busy);
endinterface
`default_nettype wire

//--- logic/fspc_engine.sv
/*
  sequencer engine: checks the setup, issues write or block erase requests
  to the flash array and reports activation, end and errors.
  assumes the array holds flash_ack high for one cycle per request.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fspc_regs.svh"
module fspc_engine (
  input  wire logic  clk,
  input  wire logic  rst_n,
  fspc_seq_if.engine seq,
  output logic       flash_req,
  output logic       flash_erase,
  output logic       flash_area,
  output logic [15:0] flash_addr,
  output logic [31:0] flash_wdata,
  output logic [4:0] flash_freq,
  input  wire logic  flash_ack,
  input  wire logic  flash_fail
);
  import fspc_pkg::*;

  fspc_state_type state;
  fspc_state_type next_state;
  logic [15:0]    cur;
  logic [15:0]    end_q;
  logic [15:0]    cur_blk;
  logic [15:0]    end_blk;
  logic           cfg_ok;
  logic           go;
  logic           reject;
  logic           fin;
  logic           abort;

  // ==========================================================
  // decision
  assign cur_blk = flash_area ? (cur >> `FSPC_SHIFT_DATA) : (cur >> `FSPC_SHIFT_CODE);
  assign end_blk = flash_area ? (end_q >> `FSPC_SHIFT_DATA) : (end_q >> `FSPC_SHIFT_CODE);
  assign cfg_ok  = seq.spm && !seq.inhibit
                   && seq.freq <= `FSPC_FREQ_MAX
                   && (seq.cmd == FSPC_CMD_WRITE || seq.cmd == FSPC_CMD_ERASE);

  always_comb begin
    next_state = state;
    go         = 1'b0;
    reject     = 1'b0;
    fin        = 1'b0;
    abort      = 1'b0;
    unique case (state)
      FSPC_ST_IDLE: begin
        if (seq.start) begin
          go         = cfg_ok;
          reject     = !cfg_ok;
          next_state = cfg_ok ? FSPC_ST_ISSUE : FSPC_ST_DONE;
        end
      end
      FSPC_ST_ISSUE: begin
        abort      = !seq.start;
        next_state = seq.start ? FSPC_ST_WAIT : FSPC_ST_IDLE;
      end
      FSPC_ST_WAIT: begin
        if (!seq.start) begin
          abort      = 1'b1;
          next_state = FSPC_ST_IDLE;
        end else if (flash_ack) begin
          if (flash_fail || !flash_erase || cur_blk >= end_blk) begin
            fin        = 1'b1;
            next_state = FSPC_ST_DONE;
          end else begin
            next_state = FSPC_ST_ISSUE;
          end
        end
      end
      FSPC_ST_DONE: begin
        if (!seq.start) begin
          next_state = FSPC_ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // state and reports
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= FSPC_ST_IDLE;
      seq.act     <= 1'b0;
      seq.done    <= 1'b0;
      seq.seq_err <= 1'b0;
      seq.wr_err  <= 1'b0;
      seq.er_err  <= 1'b0;
      seq.busy    <= 1'b0;
    end else begin
      state       <= next_state;
      seq.act     <= go || reject;
      seq.done    <= fin || reject;
      seq.seq_err <= reject;
      seq.wr_err  <= fin && flash_fail && !flash_erase;
      seq.er_err  <= fin && flash_fail && flash_erase;
      if (go) begin
        seq.busy <= 1'b1;
      end else if (fin || abort) begin
        seq.busy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flash request side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_req   <= 1'b0;
      flash_erase <= 1'b0;
      flash_area  <= 1'b0;
      flash_addr  <= 16'h0000;
      flash_wdata <= 32'h0000_0000;
      flash_freq  <= 5'h00;
      cur         <= 16'h0000;
      end_q       <= 16'h0000;
    end else begin
      if (go) begin
        flash_erase <= (seq.cmd == FSPC_CMD_ERASE);
        flash_area  <= seq.area;
        flash_wdata <= seq.wdata;
        flash_freq  <= seq.freq;
        end_q       <= seq.end_addr;
        cur         <= seq.ptr;
      end
      if (state == FSPC_ST_ISSUE && seq.start) begin
        flash_req  <= 1'b1;
        flash_addr <= cur;
      end else if (abort || (state == FSPC_ST_WAIT && flash_ack)) begin
        flash_req <= 1'b0;
        cur       <= cur + (flash_area ? `FSPC_BLK_DATA : `FSPC_BLK_CODE);
      end
    end
  end

  // ==========================================================
  // checks
  property p_write_word;
    @(posedge clk) disable iff (!rst_n)
      $rose(flash_req) && !flash_erase |-> flash_wdata == $past(seq.wdata, 3)
                                            && flash_addr == $past(seq.ptr, 3);
  endproperty
  a_write_word: assert property (p_write_word) else $error("write word wrong");

  property p_data_block;
    @(posedge clk) disable iff (!rst_n)
      flash_req && flash_erase && flash_area && flash_addr != end_q
        |-> ##[1:1000] (!flash_req || flash_addr[15:9] != $past(flash_addr[15:9]));
  endproperty
  a_data_block: assert property (p_data_block) else $error("erase step stuck");
endmodule // fspc_engine
`default_nettype wire

//--- logic/fspc_ctrl.sv
/*
  flash self-programming control: byte registers on the cpu bus, status
  flags, cpu wait and the sequencer engine.
  assumes one byte access per cycle and a flash array answering requests.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fspc_regs.svh"
module fspc_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [19:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata,
  output logic             cpu_wait,
  output logic             prog_mode,
  output logic             flash_req,
  output logic             flash_erase,
  output logic             flash_area,
  output logic [15:0]      flash_addr,
  output logic [31:0]      flash_wdata,
  output logic [4:0]       flash_freq,
  input  wire logic        flash_ack,
  input  wire logic        flash_fail
);
  import fspc_pkg::*;

  logic [7:0]  mode;
  logic [7:0]  freq;
  logic [7:0]  cmd_reg;
  logic [7:0]  wbuf [4];
  logic [15:0] ptr;
  logic [15:0] end_addr;
  logic        end_f;
  logic        seq_f;
  logic        wr_f;
  logic        er_f;
  logic [7:0]  rd_mux;
  logic        first_cyc;

  fspc_seq_if seq ();

  // ==========================================================
  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `FSPC_MODE_RESET;
    end else if (bus_wr && bus_addr == `FSPC_ADDR_MODE) begin
      mode <= bus_wdata & `FSPC_MODE_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq <= `FSPC_FREQ_RESET;
    end else if (bus_wr && bus_addr == `FSPC_ADDR_FREQ) begin
      freq <= bus_wdata & `FSPC_FREQ_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= `FSPC_CMD_RESET;
    end else if (bus_wr && bus_addr == `FSPC_ADDR_CMD) begin
      cmd_reg <= bus_wdata & `FSPC_CMD_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_mode <= 1'b0;
    end else begin
      prog_mode <= mode[`FSPC_SPM_BIT];
    end
  end

  // ==========================================================
  // data, pointer and end address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        wbuf[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bus_wr && bus_addr == `FSPC_ADDR_WB0 + 20'(i)) begin
          wbuf[i] <= bus_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr      <= 16'h0000;
      end_addr <= 16'h0000;
    end else if (bus_wr) begin
      if (bus_addr == `FSPC_ADDR_PTR_L) begin
        ptr[7:0] <= bus_wdata;
      end
      if (bus_addr == `FSPC_ADDR_PTR_H) begin
        ptr[15:8] <= bus_wdata;
      end
      if (bus_addr == `FSPC_ADDR_END_L) begin
        end_addr[7:0] <= bus_wdata;
      end
      if (bus_addr == `FSPC_ADDR_END_H) begin
        end_addr[15:8] <= bus_wdata;
      end
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      end_f <= 1'b0;
    end else if (seq.done) begin
      end_f <= 1'b1;
    end else if (!cmd_reg[`FSPC_START_BIT]) begin
      end_f <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_f <= 1'b0;
      wr_f  <= 1'b0;
      er_f  <= 1'b0;
    end else begin
      seq_f <= seq.seq_err || (seq_f && !seq.act);
      wr_f  <= seq.wr_err || (wr_f && !seq.act);
      er_f  <= seq.er_err || (er_f && !seq.act);
    end
  end

  // ==========================================================
  // read port
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_addr)
      `FSPC_ADDR_FREQ:   rd_mux = freq;
      `FSPC_ADDR_MODE:   rd_mux = mode;
      `FSPC_ADDR_CMD:    rd_mux = cmd_reg;
      `FSPC_ADDR_PTR_L:  rd_mux = ptr[7:0];
      `FSPC_ADDR_PTR_H:  rd_mux = ptr[15:8];
      `FSPC_ADDR_END_L:  rd_mux = end_addr[7:0];
      `FSPC_ADDR_END_H:  rd_mux = end_addr[15:8];
      `FSPC_ADDR_STAT_L: begin
        rd_mux[`FSPC_SEQERR_BIT] = seq_f;
        rd_mux[`FSPC_WRERR_BIT]  = wr_f;
        rd_mux[`FSPC_ERERR_BIT]  = er_f;
      end
      `FSPC_ADDR_STAT_H: rd_mux[`FSPC_END_BIT] = end_f;
      `FSPC_ADDR_WB0:    rd_mux = wbuf[0];
      `FSPC_ADDR_WB0 + 20'h1: rd_mux = wbuf[1];
      `FSPC_ADDR_WB0 + 20'h2: rd_mux = wbuf[2];
      `FSPC_ADDR_WB0 + 20'h3: rd_mux = wbuf[3];
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // sequencer engine
  assign seq.start    = cmd_reg[`FSPC_START_BIT];
  assign seq.cmd      = cmd_reg[2:0];
  assign seq.area     = mode[`FSPC_AREA_BIT];
  assign seq.inhibit  = mode[`FSPC_INHIBIT_BIT];
  assign seq.spm      = mode[`FSPC_SPM_BIT];
  assign seq.freq     = freq[4:0];
  assign seq.ptr      = ptr;
  assign seq.end_addr = end_addr;
  assign seq.wdata    = {wbuf[3], wbuf[2], wbuf[1], wbuf[0]};
  assign cpu_wait     = seq.busy;

  fspc_engine fspc_engine_inst (
    .clk         (clk),
    .rst_n       (rst_n),
    .seq         (seq.engine),
    .flash_req   (flash_req),
    .flash_erase (flash_erase),
    .flash_area  (flash_area),
    .flash_addr  (flash_addr),
    .flash_wdata (flash_wdata),
    .flash_freq  (flash_freq),
    .flash_ack   (flash_ack),
    .flash_fail  (flash_fail)
  );

  // ==========================================================
  // checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  sequence s_start_wr;
    bus_wr && bus_addr == `FSPC_ADDR_CMD && bus_wdata[7] && !cmd_reg[7] && !cpu_wait;
  endsequence

  sequence s_cfg_ok;
    mode[`FSPC_SPM_BIT] && !mode[`FSPC_INHIBIT_BIT] && freq[4:0] <= `FSPC_FREQ_MAX
      && (bus_wdata[2:0] == FSPC_CMD_WRITE || bus_wdata[2:0] == FSPC_CMD_ERASE);
  endsequence

  property p_mode_reset;
    @(posedge clk) disable iff (!rst_n) first_cyc |-> mode == 8'h08;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode reset value wrong");

  property p_other_reset;
    @(posedge clk) disable iff (!rst_n) first_cyc |-> freq == 8'h00 && cmd_reg == 8'h00;
  endproperty
  a_other_reset: assert property (p_other_reset) else $error("reset value wrong");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      (mode & 8'hd5) == 8'h00 && (freq & 8'he0) == 8'h00 && (cmd_reg & 8'h78) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_start_wait;
    @(posedge clk) disable iff (!rst_n) s_start_wr ##0 s_cfg_ok |=> ##1 cpu_wait;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("cpu wait not raised");

  property p_inhibit_err;
    @(posedge clk) disable iff (!rst_n)
      s_start_wr ##0 (mode[`FSPC_INHIBIT_BIT] || !mode[`FSPC_SPM_BIT])
        |=> (!flash_req && !cpu_wait) [*3] ##0 seq_f;
  endproperty
  a_inhibit_err: assert property (p_inhibit_err) else $error("blocked start ran");

  property p_stop;
    @(posedge clk) disable iff (!rst_n)
      cpu_wait && bus_wr && bus_addr == `FSPC_ADDR_CMD && !bus_wdata[7] |=> ##2 !cpu_wait;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not release wait");

  property p_end_flag;
    @(posedge clk) disable iff (!rst_n)
      (seq.done |=> end_f) and (end_f && cmd_reg[7] |=> end_f);
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag wrong");

  property p_err_hold;
    @(posedge clk) disable iff (!rst_n)
      (seq_f || er_f) && !seq.act |=> $stable({seq_f, er_f}) || seq.seq_err || seq.er_err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");

  // ==========================================================
  // checks on the flash side
  sequence s_go;
    $rose(cpu_wait);
  endsequence

  property p_go_latch;
    @(posedge clk) disable iff (!rst_n)
      s_go |-> flash_area == $past(mode[`FSPC_AREA_BIT])
               && flash_erase == ($past(cmd_reg[2:0]) == FSPC_CMD_ERASE);
  endproperty
  a_go_latch: assert property (p_go_latch) else $error("latch wrong");

  property p_freq_range;
    @(posedge clk) disable iff (!rst_n) flash_req |-> flash_freq <= `FSPC_FREQ_MAX;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("bad frequency code");

  property p_stop_idle;
    @(posedge clk) disable iff (!rst_n)
      !cmd_reg[`FSPC_START_BIT] |=> !flash_req && !cpu_wait;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stopped but busy");

  property p_end_clear;
    @(posedge clk) disable iff (!rst_n)
      end_f && !cmd_reg[`FSPC_START_BIT] && !seq.done |=> !end_f;
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("end flag not cleared");

  property p_ack_drop;
    @(posedge clk) disable iff (!rst_n) flash_req && flash_ack |=> !flash_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");

  property p_reject_quiet;
    @(posedge clk) disable iff (!rst_n) seq.seq_err |-> !flash_req && !cpu_wait;
  endproperty
  a_reject_quiet: assert property (p_reject_quiet) else $error("reject ran");
endmodule // fspc_ctrl
`default_nettype wire

//--- tb/fspc_flash_model.sv
/*
  behavioural flash array: answers each request after a set delay.
  assumes the sequencer holds a request until it is acknowledged.
*/
`timescale 1ns/100ps
`default_nettype none
module fspc_flash_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        flash_req,
  input  wire logic        flash_erase,
  input  wire logic        flash_area,
  input  wire logic [15:0] flash_addr,
  input  wire logic [31:0] flash_wdata,
  input  wire logic [7:0]  delay,
  input  wire logic        fail_en,
  output logic             flash_ack,
  output logic             flash_fail,
  output logic [7:0]       req_count,
  output logic [15:0]      last_addr,
  output logic [31:0]      last_wdata,
  output logic [1:0]       last_kind
);
  logic [7:0] wait_cnt;
  // ==========================================
  // request handling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt   <= 8'h00;
      flash_ack  <= 1'b0;
      flash_fail <= 1'b0;
      req_count  <= 8'h00;
      last_addr  <= 16'h0000;
      last_wdata <= 32'h00000000;
      last_kind  <= 2'h0;
    end else if (flash_ack || !flash_req) begin
      // fail line is meaningless outside ack, so keep it moving
      flash_ack  <= 1'b0;
      wait_cnt   <= 8'h00;
      flash_fail <= ~flash_fail;
    end else if (wait_cnt == delay) begin
      flash_ack  <= 1'b1;
      flash_fail <= fail_en;
      req_count  <= req_count + 8'h01;
      last_addr  <= flash_addr;
      last_wdata <= flash_wdata;
      last_kind  <= {flash_erase, flash_area};
    end else begin
      wait_cnt   <= wait_cnt + 8'h01;
      flash_fail <= ~flash_fail;
    end
  end
endmodule // fspc_flash_model
`default_nettype wire

//--- tb/fspc_ctrl_tb_top.sv
/*
  testbench for the flash self-programming control block.
  assumes the byte register bus and flash link of fspc_ctrl.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fspc_regs.svh"
module fspc_ctrl_tb_top;
  logic        clk, rst_n, bus_wr, bus_rd, cpu_wait, prog_mode;
  logic        flash_req, flash_erase, flash_area, flash_ack, flash_fail, fail_en;
  logic [19:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, delay, req_count, base;
  logic [15:0] flash_addr, last_addr;
  logic [31:0] flash_wdata, last_wdata;
  logic [4:0]  flash_freq;
  logic [1:0]  last_kind;
  int          fail_count, checks_done, k;
  logic [2:0]  bad_codes [6] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};

  fspc_ctrl fspc_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cpu_wait(cpu_wait),
    .prog_mode(prog_mode), .flash_req(flash_req), .flash_erase(flash_erase),
    .flash_area(flash_area), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_freq(flash_freq), .flash_ack(flash_ack), .flash_fail(flash_fail));
  fspc_flash_model fspc_flash_model_inst (.clk(clk), .rst_n(rst_n), .flash_req(flash_req),
    .flash_erase(flash_erase), .flash_area(flash_area), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .delay(delay), .fail_en(fail_en), .flash_ack(flash_ack),
    .flash_fail(flash_fail), .req_count(req_count), .last_addr(last_addr),
    .last_wdata(last_wdata), .last_kind(last_kind));

  always #5 clk = ~clk;

  // ==========================================
  // bus and compare tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string what);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(what, {24'h0, e}, {24'h0, bus_rdata & m});
  endtask
  task automatic start(input logic [7:0] cmd);
    base = req_count;
    wr(`FSPC_ADDR_CMD, cmd);
  endtask
  task automatic wait_req;
    int i;
    for (i = 0; i < 20 && flash_req !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  // end of operation, status flags, stop and flag persistence
  task automatic finish(input logic [7:0] nreq, input logic [7:0] m, input logic [7:0] e,
                        input string what);
    int i;
    repeat (3) @(posedge clk);
    for (i = 0; i < 400 && cpu_wait !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    rd(`FSPC_ADDR_STAT_H, 8'hff, 8'h40, what);
    rd(`FSPC_ADDR_STAT_L, m, e, what);
    chk(what, {24'h0, nreq}, {24'h0, req_count - base});
    wr(`FSPC_ADDR_CMD, 8'h00);
    repeat (2) @(posedge clk);
    rd(`FSPC_ADDR_STAT_H, 8'hff, 8'h00, what);
    rd(`FSPC_ADDR_STAT_L, m, e, what);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  // ==========================================
  // main sequence
  initial begin
    clk = 0; rst_n = 0; bus_addr = 0; bus_wr = 0; bus_rd = 0; bus_wdata = 0;
    delay = 8'h03; fail_en = 0; fail_count = 0; checks_done = 0; base = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`FSPC_ADDR_MODE, 8'hff, 8'h08, "mode reset");
    rd(`FSPC_ADDR_FREQ, 8'hff, 8'h00, "freq reset");
    rd(`FSPC_ADDR_CMD, 8'hff, 8'h00, "cmd reset");
    wr(`FSPC_ADDR_MODE, 8'hff);
    rd(`FSPC_ADDR_MODE, 8'hff, 8'h2a, "mode reserved");
    chk("prog_mode on", 1, prog_mode);
    wr(`FSPC_ADDR_FREQ, 8'hff);
    rd(`FSPC_ADDR_FREQ, 8'hff, 8'h1f, "freq reserved");
    wr(`FSPC_ADDR_CMD, 8'h78);
    rd(`FSPC_ADDR_CMD, 8'hff, 8'h00, "cmd reserved");
    wr(20'hf00bf, 8'h55);
    rd(20'hf00bf, 8'hff, 8'h00, "unmapped");
    wr(`FSPC_ADDR_FREQ, 8'h0f);
    start(8'h81);
    finish(0, 8'h13, 8'h10, "inhibited start");
    wr(`FSPC_ADDR_MODE, 8'h20);
    start(8'h81);
    finish(0, 8'h13, 8'h10, "read mode start");
    chk("prog_mode off", 0, prog_mode);
    wr(`FSPC_ADDR_MODE, 8'h02);
    for (k = 0; k < 6; k++) begin
      start({5'h10, bad_codes[k]});
      finish(0, 8'h13, 8'h10, "bad command");
    end
    wr(`FSPC_ADDR_FREQ, 8'h10);
    start(8'h81);
    finish(0, 8'h13, 8'h10, "freq above range");
    wr(`FSPC_ADDR_FREQ, 8'h0f);
    // word write to code area
    wr(`FSPC_ADDR_PTR_L, 8'h34);
    wr(`FSPC_ADDR_PTR_H, 8'h12);
    for (k = 0; k < 4; k++) wr(`FSPC_ADDR_WB0 + 20'(k), 8'(8'h11 * (k + 1)));
    start(8'h81);
    wait_req();
    chk("cpu_wait busy", 1, cpu_wait);
    chk("freq code", 5'h0f, flash_freq);
    chk("write addr", 16'h1234, flash_addr);
    chk("write word", 32'h44332211, flash_wdata);
    chk("write kind", 2'b00, {flash_erase, flash_area});
    finish(1, 8'h13, 8'h00, "word write");
    chk("array word", 32'h44332211, last_wdata);
    // block erase, data area, 512-byte blocks 1..3
    wr(`FSPC_ADDR_MODE, 8'h22);
    wr(`FSPC_ADDR_PTR_L, 8'h00);
    wr(`FSPC_ADDR_PTR_H, 8'h03);
    wr(`FSPC_ADDR_END_L, 8'h00);
    wr(`FSPC_ADDR_END_H, 8'h07);
    start(8'h84);
    finish(3, 8'h13, 8'h00, "data erase");
    chk("data last block", {2'b11, 16'h0700}, {last_kind, last_addr});
    // block erase, code area, 1 Kbyte blocks 1..2
    wr(`FSPC_ADDR_MODE, 8'h02);
    wr(`FSPC_ADDR_PTR_H, 8'h04);
    wr(`FSPC_ADDR_END_L, 8'hff);
    wr(`FSPC_ADDR_END_H, 8'h0b);
    start(8'h84);
    finish(2, 8'h13, 8'h00, "code erase");
    chk("code last block", {2'b10, 16'h0800}, {last_kind, last_addr});
    // write, then erase, failing at their first request
    fail_en = 1'b1;
    start(8'h81);
    finish(1, 8'h13, 8'h02, "write fail");
    start(8'h84);
    finish(1, 8'h13, 8'h01, "erase fail");
    fail_en = 1'b0;
    // abort by clearing start while busy
    delay = 8'h28;
    start(8'h81);
    wait_req();
    wr(`FSPC_ADDR_CMD, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk("abort wait", 0, cpu_wait);
    chk("abort req", 0, flash_req);
    delay = 8'h03;
    wr(`FSPC_ADDR_CMD, 8'h00);
    tally_and_finish();
  end
endmodule // fspc_ctrl_tb_top
`default_nettype wire
